// [core/ddc_nco_decimator.sv]
// Oscillator, mixer, decimating filter, output FIFO and register port
//
// Summary of operation
// - complex mode: shift, low-pass, then decimate
// - complex mode offers 6 dB gain option
// - real mode: no shift, real output
// - real mode offers 3 dB gain option
// - complex mode: quarter-rate mix gives real output, twice rate
// - 32-bit oscillator multiplies each input sample outside real mode
// - frequency word is signed, plus/minus half rate
// - new frequency waits for restart or sync
// - invert option subtracts oscillator frequency
// - decimation by 2, 4, 8, 16, 32
// - passband 0.8 complex, 0.4 real
// - stopbands set by a boxcar average, far below half-band rejection
// - real mode bypasses the mixer
// - filter accumulates at 25 bits, saturates to 20-bit output
// - sync clears dividers, phase, loads frequency
`timescale 1ns/1ps

module sample_fifo #(
	parameter int WIDTH = 40,
	parameter int DEPTH = 8
) (
	input  wire logic             sys_clk,
	input  wire logic             nrst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int PTR_W = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic [PTR_W:0]   count;
	logic             push;
	logic             pop;

	assign in_ready  = (count != (PTR_W+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Depth must be a power of two so the pointers wrap on their own
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end
endmodule

module ddc_nco_decimator (
	input  wire logic                            sys_clk,
	input  wire logic                            nrst,
	input  wire logic [ddc_pkg::ADDR_W-1:0]      reg_addr,
	input  wire logic [ddc_pkg::DATA_W-1:0]      reg_wdata,
	input  wire logic                            reg_wr,
	input  wire logic                            reg_rd,
	output logic [ddc_pkg::DATA_W-1:0]           reg_rdata,
	input  wire logic signed [ddc_pkg::ADC_W-1:0] adc_sample,
	input  wire logic                            powerdown_or_alignment_pin,
	input  wire logic                            out_ready,
	output ddc_pkg::iq_type                      out_sample,
	output logic                                 out_valid,
	output logic                                 out_real
);
	import ddc_pkg::*;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic signed [LUT_W:0] sine_of(input logic [4:0] ph);
		logic signed [LUT_W:0] mag;
		mag = ph[3] ? $signed({1'b0, SINE_TABLE[4'h8 - {1'b0, ph[2:0]}]})
			: $signed({1'b0, SINE_TABLE[{1'b0, ph[2:0]}]});
		return ph[4] ? -mag : mag;
	endfunction

	function automatic logic signed [SAMPLE_W-1:0] saturate(input logic signed [SAMPLE_W+1:0] w);
		if (w > SAT_MAX)
			return SAT_MAX;
		else if (w < SAT_MIN)
			return SAT_MIN;
		return w[SAMPLE_W-1:0];
	endfunction

	function automatic logic signed [SAMPLE_W-1:0] negate(input logic signed [SAMPLE_W-1:0] x);
		return saturate(-{{2{x[SAMPLE_W-1]}}, x});
	endfunction

	// ****************************************
	// Register port
	// ****************************************
	ctrl_type       ctrl;
	ctrl_type       next_ctrl;
	logic [NCO_W-1:0] freq_pending;
	logic [NCO_W-1:0] freq_active;
	logic [NCO_W-1:0] phase;
	logic           overflow;
	logic           restart_evt;
	logic           fifo_in_ready;
	logic           fifo_out_valid;
	iq_type         fifo_data;
	logic           filt_valid;

	always_comb
	begin
		next_ctrl = ctrl_type'(reg_wdata);
		next_ctrl.unused = '0;
		if (next_ctrl.decim > DECIM_CODE_MAX)
			next_ctrl.decim = DECIM_CODE_MAX;
	end

	// Either edge of the restart bit counts as a toggle
	assign restart_evt = reg_wr && (reg_addr == CTRL_ADDR) && (next_ctrl.restart != ctrl.restart);

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			ctrl         <= ctrl_type'(CTRL_RESET);
			freq_pending <= FREQ_RESET;
		end
		else if (reg_wr && reg_addr == CTRL_ADDR)
			ctrl <= next_ctrl;
		else if (reg_wr && reg_addr == FREQ_ADDR)
			freq_pending <= reg_wdata;
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
			overflow <= 1'b0;
		else if (filt_valid && !fifo_in_ready)
			overflow <= 1'b1;
		else if (reg_wr && reg_addr == STATUS_ADDR && reg_wdata[STAT_OVF_BIT])
			overflow <= 1'b0;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
			reg_rdata <= '0;
		else if (reg_rd)
			case (reg_addr)
				CTRL_ADDR:   reg_rdata <= DATA_W'(ctrl);
				FREQ_ADDR:   reg_rdata <= freq_pending;
				STATUS_ADDR: reg_rdata <= DATA_W'({freq_pending != freq_active, !fifo_out_valid, overflow});
				ACTIVE_ADDR: reg_rdata <= freq_active;
				default:     reg_rdata <= '0;
			endcase
		else
			reg_rdata <= '0;
	end

	// ****************************************
	// Alignment input
	// ****************************************
	logic sync_meta;
	logic sync_level;
	logic sync_prev;
	logic sync_evt;

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			sync_meta  <= 1'b0;
			sync_level <= 1'b0;
			sync_prev  <= 1'b0;
		end
		else
		begin
			sync_meta  <= powerdown_or_alignment_pin;
			sync_level <= sync_meta;
			sync_prev  <= sync_level;
		end
	end

	// Resync mid-stream keeps divider phase only on 64-cycle multiples
	assign sync_evt = restart_evt || (ctrl.sync_en && sync_level && !sync_prev);

	// ****************************************
	// Oscillator
	// ****************************************
	// Two's complement wrap covers minus to plus half the rate
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			phase       <= '0;
			freq_active <= FREQ_RESET;
		end
		else if (sync_evt)
		begin
			phase       <= '0;
			freq_active <= freq_pending;
		end
		else
			phase <= phase + freq_active;
	end

	// ****************************************
	// Mixer
	// ****************************************
	logic signed [LUT_W:0]       cos_v;
	logic signed [LUT_W:0]       sin_v;
	logic signed [ADC_W+LUT_W:0] prod_i;
	logic signed [ADC_W+LUT_W:0] prod_q;
	logic signed [SAMPLE_W-1:0]  mix_i;
	logic signed [SAMPLE_W-1:0]  mix_q;
	logic                        mix_valid;

	// 32-point wave keeps area small; spurs limit dynamic range
	always_comb
	begin
		cos_v  = sine_of(phase[NCO_W-1:NCO_W-5] + QUARTER_TURN);
		sin_v  = ctrl.invert ? -sine_of(phase[NCO_W-1:NCO_W-5]) : sine_of(phase[NCO_W-1:NCO_W-5]);
		prod_i = adc_sample * cos_v;
		prod_q = adc_sample * sin_v;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			mix_i     <= '0;
			mix_q     <= '0;
			mix_valid <= 1'b0;
		end
		else
		begin
			mix_valid <= ctrl.enable;
			if (ctrl.real_mode)
			begin
				mix_i <= {adc_sample, 6'h00};
				mix_q <= '0;
			end
			else
			begin
				mix_i <= prod_i[SAMPLE_W+4:5];
				mix_q <= prod_q[SAMPLE_W+4:5];
			end
		end
	end

	// ****************************************
	// Decimating filter
	// ****************************************
	// Boxcar integrate-and-dump: cheap, but its alias rejection is far
	// from that of a long half-band chain
	logic signed [ACC_W-1:0]    acc_i;
	logic signed [ACC_W-1:0]    acc_q;
	logic signed [ACC_W-1:0]    next_acc_i;
	logic signed [ACC_W-1:0]    next_acc_q;
	logic signed [ACC_W-1:0]    scaled_i;
	logic signed [ACC_W-1:0]    scaled_q;
	logic [4:0]                 dec_cnt;
	logic [4:0]                 dec_last;
	iq_type                     filt_data;
	logic signed [SAMPLE_W+1:0] wide_i;
	logic signed [SAMPLE_W+1:0] wide_q;

	always_comb
	begin
		dec_last   = 5'((6'h02 << ctrl.decim) - 6'h01);
		next_acc_i = acc_i + mix_i;
		next_acc_q = acc_q + mix_q;
		scaled_i   = next_acc_i >>> (ctrl.decim + 3'h1);
		scaled_q   = next_acc_q >>> (ctrl.decim + 3'h1);
		wide_i     = scaled_i[SAMPLE_W+1:0];
		wide_q     = scaled_q[SAMPLE_W+1:0];
		if (ctrl.gain && ctrl.real_mode)
			wide_i = wide_i + (wide_i >>> 2) + (wide_i >>> 3) + (wide_i >>> 5);
		else if (ctrl.gain)
		begin
			wide_i = wide_i <<< 1;
			wide_q = wide_q <<< 1;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst || !ctrl.enable || sync_evt)
		begin
			acc_i      <= '0;
			acc_q      <= '0;
			dec_cnt    <= '0;
			filt_valid <= 1'b0;
			filt_data  <= '0;
		end
		else if (mix_valid && dec_cnt == dec_last)
		begin
			acc_i       <= '0;
			acc_q       <= '0;
			dec_cnt     <= '0;
			filt_valid  <= 1'b1;
			filt_data.i <= saturate(wide_i);
			filt_data.q <= ctrl.real_mode ? '0 : saturate(wide_q);
		end
		else
		begin
			filt_valid <= 1'b0;
			if (mix_valid)
			begin
				acc_i   <= next_acc_i;
				acc_q   <= next_acc_q;
				dec_cnt <= dec_cnt + 5'h01;
			end
		end
	end

	// ****************************************
	// Output buffer and emitter
	// ****************************************
	// The converter cannot be stalled: a full buffer drops and flags
	emit_state_type             state;
	logic signed [SAMPLE_W-1:0] held;
	logic                       rot;
	logic                       fifo_pop;

	sample_fifo #(
		.WIDTH ($bits(iq_type)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.nrst      (nrst),
		.in_valid  (filt_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (filt_data),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_data)
	);

	assign fifo_pop = fifo_out_valid && out_ready && !out_valid && (state == EMIT_IDLE);

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			state      <= EMIT_IDLE;
			out_valid  <= 1'b0;
			out_sample <= '0;
			out_real   <= 1'b0;
			held       <= '0;
			rot        <= 1'b0;
		end
		else
		begin
			out_valid <= 1'b0;
			if (sync_evt)
				rot <= 1'b0;
			case (state)
				EMIT_IDLE:
					if (fifo_pop && ctrl.fs4 && !ctrl.real_mode)
					begin
						out_sample <= '{rot ? negate(fifo_data.i) : fifo_data.i, '0};
						held       <= rot ? fifo_data.q : negate(fifo_data.q);
						out_real   <= 1'b1;
						out_valid  <= 1'b1;
						rot        <= ~rot;
						state      <= EMIT_SECOND;
					end
					else if (fifo_pop)
					begin
						out_sample <= fifo_data;
						out_real   <= ctrl.real_mode;
						out_valid  <= 1'b1;
					end
				EMIT_SECOND:
					if (out_ready && !out_valid)
					begin
						out_sample <= '{held, '0};
						out_valid  <= 1'b1;
						state      <= EMIT_IDLE;
					end
				default:
					state <= EMIT_IDLE;
			endcase
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_sync_phase_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
		sync_evt |=> phase == '0) else $error("phase not cleared by sync");
	a_sync_freq_load: assert property (@(posedge sys_clk) disable iff (!nrst)
		sync_evt |=> freq_active == $past(freq_pending)) else $error("frequency not loaded by sync");
	a_freq_held_until: assert property (@(posedge sys_clk) disable iff (!nrst)
		!sync_evt |=> $stable(freq_active)) else $error("frequency changed without sync");
	a_phase_step: assert property (@(posedge sys_clk) disable iff (!nrst)
		!sync_evt |=> phase == $past(phase) + $past(freq_active)) else $error("phase step wrong");
	a_real_bypass: assert property (@(posedge sys_clk) disable iff (!nrst)
		ctrl.real_mode |=> mix_q == '0 && mix_i == {$past(adc_sample), 6'h00}) else $error("mixer not bypassed");
	a_dump_count: assert property (@(posedge sys_clk) disable iff (!nrst)
		$rose(filt_valid) |-> $past(dec_cnt) == $past(dec_last)) else $error("dump at wrong count");
	a_strobe_single: assert property (@(posedge sys_clk) disable iff (!nrst)
		out_valid |=> !out_valid) else $error("valid longer than one cycle");
	a_fs4_pair: assert property (@(posedge sys_clk) disable iff (!nrst)
		$rose(state == EMIT_SECOND) |-> out_valid && out_real) else $error("first real half missing");
	a_overflow_sticky: assert property (@(posedge sys_clk) disable iff (!nrst)
		overflow && !(reg_wr && reg_addr == STATUS_ADDR) |=> overflow) else $error("overflow flag lost");
endmodule

// [core/ddc_pkg.sv]
// Shared constants and types of the down-converter
package ddc_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int ADC_W    = 14;
	localparam int SAMPLE_W = 20;
	localparam int ACC_W    = SAMPLE_W + 5;
	localparam int NCO_W    = 32;
	localparam int LUT_W    = 12;
	localparam int ADDR_W   = 4;
	localparam int DATA_W   = 32;
	localparam int FIFO_DEPTH = 8;

	// ****************************************
	// Register map and reset values
	// ****************************************
	localparam logic [ADDR_W-1:0] CTRL_ADDR   = 4'h0;
	localparam logic [ADDR_W-1:0] FREQ_ADDR   = 4'h1;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h2;
	localparam logic [ADDR_W-1:0] ACTIVE_ADDR = 4'h3;
	localparam logic [DATA_W-1:0] CTRL_RESET  = 32'h00000000;
	localparam logic [NCO_W-1:0]  FREQ_RESET  = 32'h00000000;
	localparam int                STAT_OVF_BIT = 0;
	localparam logic [2:0]        DECIM_CODE_MAX = 3'h4;
	localparam logic [4:0]        QUARTER_TURN   = 5'h08;

	// ****************************************
	// Arithmetic limits and quarter-wave sine
	// ****************************************
	localparam logic signed [SAMPLE_W-1:0] SAT_MAX = 20'h7FFFF;
	localparam logic signed [SAMPLE_W-1:0] SAT_MIN = 20'h80000;
	localparam logic [LUT_W-1:0] SINE_TABLE [0:8] = '{12'h000, 12'h190, 12'h310, 12'h472, 12'h5A8,
		12'h6A6, 12'h764, 12'h7D8, 12'h7FF};

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic [21:0] unused;
		logic        sync_en;
		logic        restart;
		logic [2:0]  decim;
		logic        invert;
		logic        gain;
		logic        fs4;
		logic        real_mode;
		logic        enable;
	} ctrl_type;

	typedef struct packed {
		logic signed [SAMPLE_W-1:0] i;
		logic signed [SAMPLE_W-1:0] q;
	} iq_type;

	typedef enum {EMIT_IDLE, EMIT_SECOND} emit_state_type;

endpackage

// [verification/adc_formatter_model.sv]
// Converter core source and formatter sink around the down-converter
`timescale 1ns/1ps

module adc_formatter_model (
	input  wire logic                             sys_clk,
	input  wire logic signed [ddc_pkg::ADC_W-1:0] level,
	input  wire logic                             stall,
	output logic signed [ddc_pkg::ADC_W-1:0]      adc_sample,
	output logic                                  out_ready
);
	import ddc_pkg::*;
	// A fresh sample every clock; the core never pauses the stream
	always_ff @(posedge sys_clk)
	begin
		adc_sample <= level;
		out_ready  <= !stall;
	end
endmodule

// [verification/ddc_nco_decimator_tb.sv]
// Self-checking bench for the down-converter
`timescale 1ns/1ps

module ddc_nco_decimator_tb;
	import ddc_pkg::*;
	logic                    sys_clk;
	logic                    nrst;
	logic [ADDR_W-1:0]       reg_addr;
	logic [DATA_W-1:0]       reg_wdata;
	logic                    reg_wr;
	logic                    reg_rd;
	logic [DATA_W-1:0]       reg_rdata;
	logic signed [ADC_W-1:0] adc_sample;
	logic signed [ADC_W-1:0] level;
	logic                    stall;
	logic                    pin;
	logic                    out_ready;
	iq_type                  out_sample;
	logic                    out_valid;
	logic                    out_real;
	int                      err_total;
	int                      comparisons;
	int                      cyc;
	int                      g;
	logic [DATA_W-1:0]       d;
	iq_type                  s;
	logic signed [19:0]      q0;

	ddc_nco_decimator DUT (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_sample(adc_sample),
		.powerdown_or_alignment_pin(pin), .out_ready(out_ready), .out_sample(out_sample),
		.out_valid(out_valid), .out_real(out_real));
	adc_formatter_model far (.sys_clk(sys_clk), .level(level), .stall(stall), .adc_sample(adc_sample),
		.out_ready(out_ready));

	// ****
	// Shared tasks
	// ****
	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string what);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic near(input logic signed [19:0] got, input int exp, input string what);
		comparisons++;
		if ($isunknown(got) || got > exp + 2 || got < exp - 2)
		begin
			err_total++;
			$display("Error at %0t: %s got %0d expected %0d", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
		check(d, exp, "register read");
	endtask

	// Disable long enough to drain the FIFO, then restart so dividers line up
	task automatic setup(input logic [DATA_W-1:0] c);
		wr(CTRL_ADDR, 32'h0);
		repeat (40) @(posedge sys_clk);
		wr(CTRL_ADDR, c | 32'h100);
	endtask

	// Waits for the next output strobe, returns it and the cycles waited in this call
	task automatic get(output iq_type o, output int gap);
		gap = 0;
		do
		begin
			@(posedge sys_clk);
			#1;
			gap++;
		end
		while (out_valid !== 1'b1 && gap < 400);
		if (out_valid !== 1'b1)
		begin
			err_total++;
			$display("Error at %0t: no output sample", $time);
			close_out();
		end
		o = out_sample;
	endtask

	// ****
	// Scenarios
	// ****
	task automatic t_regs();
		rchk(CTRL_ADDR, CTRL_RESET);
		rchk(FREQ_ADDR, FREQ_RESET);
		rchk(STATUS_ADDR, 32'h2);
		// Read data stands one cycle only, then drops back to zero
		@(posedge sys_clk);
		#1;
		check(reg_rdata, 32'h0, "read data idle");
		rchk(ACTIVE_ADDR, 32'h0);
		wr(4'hA, 32'hFFFFFFFF);
		rchk(4'hA, 32'h0);
		// Out-of-range decimation codes are stored as the largest one
		wr(CTRL_ADDR, 32'hE0);
		rchk(CTRL_ADDR, 32'h80);
	endtask

	task automatic t_freq();
		wr(FREQ_ADDR, 32'hFFFF0000);
		rchk(ACTIVE_ADDR, 32'h0);
		rchk(STATUS_ADDR, 32'h6);
		wr(CTRL_ADDR, 32'h100);
		rchk(ACTIVE_ADDR, 32'hFFFF0000);
		wr(FREQ_ADDR, 32'h40000000);
		wr(CTRL_ADDR, 32'h300);
		rchk(ACTIVE_ADDR, 32'hFFFF0000);
		// Pin moves on a clock edge, at a 64-cycle boundary
		do
		begin
			@(posedge sys_clk);
		end
		while (cyc % 64 != 0);
		pin <= 1'b1;
		repeat (6) @(posedge sys_clk);
		pin <= 1'b0;
		rchk(ACTIVE_ADDR, 32'h40000000);
	endtask

	// Active word is nonzero here, so any mixing would spoil the flat level
	task automatic t_real();
		for (int k = 0; k <= 4; k++)
		begin
			setup(32'h3 | (32'(k) << 5));
			get(s, g);
			get(s, g);
			check(32'(g), 32'(2 << k), "real spacing");
			check(32'(s.i), 32'(6400), "real value");
			check(32'(s.q), 32'h0, "real q");
			check({31'h0, out_real}, 32'h1, "real flag");
		end
		setup(32'hB);
		get(s, g);
		get(s, g);
		near(s.i, 9000, "real gain");
	endtask

	task automatic t_complex();
		wr(FREQ_ADDR, 32'h0);
		setup(32'h1);
		get(s, g);
		get(s, g);
		near(s.i, 6396, "complex i");
		check(32'(s.q), 32'h0, "complex q");
		check({31'h0, out_real}, 32'h0, "complex flag");
		setup(32'h9);
		get(s, g);
		get(s, g);
		near(s.i, 12792, "complex gain");
	endtask

	task automatic t_fs4();
		int exp [4] = '{6396, 0, -6396, 0};
		setup(32'h45);
		for (int n = 0; n < 4; n++)
		begin
			get(s, g);
			near(s.i, exp[n], "quarter mix");
			check({31'h0, out_real}, 32'h1, "quarter flag");
		end
	endtask

	task automatic t_invert();
		wr(FREQ_ADDR, 32'h40000000);
		setup(32'h1);
		get(s, g);
		get(s, g);
		q0 = s.q;
		check({31'h0, q0 == 0}, 32'h0, "quadrature present");
		setup(32'h11);
		get(s, g);
		get(s, g);
		near(s.q, -int'(q0), "inverted q");
	endtask

	// A stalled formatter fills the FIFO; exactly its depth drains afterwards
	task automatic t_fifo();
		int n;
		n = 0;
		stall <= 1'b1;
		setup(32'h3);
		repeat (60) @(posedge sys_clk);
		rchk(STATUS_ADDR, 32'h1);
		wr(CTRL_ADDR, 32'h100);
		stall <= 1'b0;
		repeat (60)
		begin
			@(posedge sys_clk);
			#1;
			if (out_valid === 1'b1)
				n++;
		end
		check(32'(n), 32'(FIFO_DEPTH), "drained count");
		wr(STATUS_ADDR, 32'h1);
		rchk(STATUS_ADDR, 32'h2);
	endtask

	// ****
	// Clock, reset and main sequence
	// ****
	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk)
		cyc <= cyc + 1;

	initial
	begin
		nrst = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		level = 14'sd100;
		stall = 1'b0;
		pin = 1'b0;
		err_total = 0;
		comparisons = 0;
		cyc = 0;
		repeat (20) @(posedge sys_clk);
		nrst <= 1'b1;
		t_regs();
		t_freq();
		t_real();
		t_complex();
		t_fs4();
		t_invert();
		t_fifo();
		close_out();
	end
endmodule
